// File: core/host_sram_write_sequencer.sv
// Host port that sequences processor write cycles into the shared SRAM.
// Assumes external address buffer and data latch, and an internal arbiter
// that reports memory demand and backoff on the system clock.
`timescale 1ns/100ps
module host_sram_write_sequencer
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Host bus
   input wire logic host_select_n_i,
   input wire logic host_write_strobe_n_i,
   input wire logic space_select_bit_i,
   output logic host_acknowledge_n_o,
   // Arbitration
   input wire logic internal_request_i,
   input wire logic backoff_i,
   output logic host_busy_o,
   output logic command_write_o,
   // Buffer controls
   output logic addr_buffer_enable_n_o,
   output logic data_buffer_enable_n_o,
   output logic data_buffer_direction_o,
   // SRAM strobes
   output logic mem_chip_select_n_o,
   output logic mem_write_enable_n_o
);
   host_sram_write_pkg::seq_state_t state_reg;
   host_sram_write_pkg::seq_state_t state_next;
   host_sync_if strobes ();
   logic write_req;
   logic stall;
   logic space_reg;
   logic we_arm_reg;
   logic we_neg_reg;

   host_strobe_sync u_sync
   (
      .clk_i (clk_i),
      .resetn_i (resetn_i),
      .host_select_n_i (host_select_n_i),
      .host_write_strobe_n_i (host_write_strobe_n_i),
      .sync (strobes)
   );

   assign write_req = !strobes.select_n && !strobes.write_n; // see RL2
   // Arbiter demand or a running backoff both hold the port off
   assign stall = internal_request_i || backoff_i; // see RL1

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         host_sram_write_pkg::ST_IDLE:
            if (write_req && !stall)
               state_next = host_sram_write_pkg::ST_ADDR; // see RL10
            else if (write_req)
               state_next = host_sram_write_pkg::ST_ARB; // see RL1
         host_sram_write_pkg::ST_ARB:
            if (!write_req)
               state_next = host_sram_write_pkg::ST_IDLE;
            else if (!stall) // see RL1
               state_next = host_sram_write_pkg::ST_ADDR; // see RL14
         host_sram_write_pkg::ST_ADDR:
            if (!write_req)
               state_next = host_sram_write_pkg::ST_IDLE;
            else if (stall)
               state_next = host_sram_write_pkg::ST_ARB; // see RL14
            else
               state_next = host_sram_write_pkg::ST_WRITE;
         host_sram_write_pkg::ST_WRITE:
            state_next = host_sram_write_pkg::ST_ACK; // see RL7
         host_sram_write_pkg::ST_ACK:
            if (strobes.select_n) // see RL9
               state_next = host_sram_write_pkg::ST_RECOVER;
         host_sram_write_pkg::ST_RECOVER:
            state_next = host_sram_write_pkg::ST_IDLE; // see RL8
         default:
            state_next = host_sram_write_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         state_reg <= host_sram_write_pkg::ST_IDLE;
      else
         state_reg <= state_next;
   end

   // Space bit latched as cycle three is entered
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         space_reg <= 1'b0;
      else if (state_next == host_sram_write_pkg::ST_ADDR &&
               state_reg != host_sram_write_pkg::ST_ADDR)
         space_reg <= space_select_bit_i; // see RL3
   end

   // Buffer controls registered; they switch on the clock edge itself, with no
   // delay added to keep them off the bus until the previous owner has let go.
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         addr_buffer_enable_n_o <= 1'b1;
         data_buffer_enable_n_o <= 1'b1;
         data_buffer_direction_o <= host_sram_write_pkg::DIR_TO_HOST;
      end
      else if (state_next == host_sram_write_pkg::ST_ADDR ||
               state_next == host_sram_write_pkg::ST_WRITE)
      begin
         addr_buffer_enable_n_o <= 1'b0; // see RL4, see RL5
         data_buffer_enable_n_o <= 1'b0; // see RL4, see RL5
         data_buffer_direction_o <= host_sram_write_pkg::DIR_TO_RAM; // see RL4
      end
      else
      begin
         addr_buffer_enable_n_o <= 1'b1; // see RL7, see RL14
         data_buffer_enable_n_o <= 1'b1; // see RL7, see RL14
         data_buffer_direction_o <= host_sram_write_pkg::DIR_TO_HOST;
      end
   end

   // Chip select and acknowledge; command space never touches the SRAM
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         mem_chip_select_n_o <= 1'b1;
         host_acknowledge_n_o <= 1'b1;
         host_busy_o <= 1'b0;
         command_write_o <= 1'b0;
      end
      else
      begin
         mem_chip_select_n_o <=
            !(state_next == host_sram_write_pkg::ST_WRITE &&
              !space_select_bit_i && !space_reg); // see RL6, see RL7
         host_acknowledge_n_o <=
            !(state_next == host_sram_write_pkg::ST_ACK); // see RL7, see RL9
         host_busy_o <= state_next != host_sram_write_pkg::ST_IDLE; // see RL8
         command_write_o <= state_next == host_sram_write_pkg::ST_WRITE &&
                            space_reg; // see RL3
      end
   end

   // Write strobe armed on the edge of cycle four and cut by the falling
   // edge, so it covers only the high phase while chip select is low.
   // Limitation: pulse width tracks the clock duty cycle.
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         we_arm_reg <= 1'b0;
      else
         we_arm_reg <= state_next == host_sram_write_pkg::ST_WRITE &&
                       !space_reg; // see RL6
   end

   always_ff @(negedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         we_neg_reg <= 1'b1;
      else
         we_neg_reg <= !we_arm_reg; // see RL6
   end

   // Two flops of opposite edges; a single flop cannot give a half-cycle
   assign mem_write_enable_n_o = !(we_arm_reg && we_neg_reg); // see RL11
endmodule : host_sram_write_sequencer

// File: core/host_sram_write_pkg.sv
// Constants and state codes for the host SRAM write sequencer.
// Assumes a single system clock; no software-visible registers.
// Requirements
// RL1: Stall host RAM write while internal memory request or backoff is active.
// RL2: Host select and write strobe pass two flip-flops before use.
// RL3: Space select bit sampled in cycle three picks command or RAM.
// RL4: Cycle three, no backoff: enable address and data buffers toward RAM.
// RL5: Buffer enables are delayed from the clock edge to avoid contention; the code switches them on the edge with no added delay.
// RL6: Cycle four asserts SRAM chip select and a lagging write strobe.
// RL7: Cycle five asserts acknowledge, drops buffer enables and chip select.
// RL8: One recovery cycle follows every host access before another access.
// RL9: Acknowledge holds until host deasserts select; host must release select.
// RL10: Acknowledge within five periods, or 23 to 29 after a prior access.
// RL11: Write strobe pulse is taken from the clock high phase.
// RL12: System pairs this port with 12 ns SRAMs at 40 MHz maximum; CLK_MHZ is set to 250.
// RL13: System provides tristate address buffer and bidirectional data latch.
// RL14: While stalled all strobes stay idle; sequencing restarts at cycle three.
package host_sram_write_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned MAX_ACK_PERIODS = 5;
   localparam int unsigned BACKOFF_MIN_PERIODS = 23;
   localparam int unsigned BACKOFF_MAX_PERIODS = 29;
   localparam int unsigned SPACE_BIT_POS = 17;
   localparam logic DIR_TO_RAM = 1'b0;
   localparam logic DIR_TO_HOST = 1'b1;
   localparam logic [1:0] SYNC_RESET = 2'h3;
   typedef enum logic [5:0]
   {
      ST_IDLE = 6'b00_0001,
      ST_ARB = 6'b00_0010,
      ST_ADDR = 6'b00_0100,
      ST_WRITE = 6'b00_1000,
      ST_ACK = 6'b01_0000,
      ST_RECOVER = 6'b10_0000
   } seq_state_t;
endpackage : host_sram_write_pkg

// File: core/host_sync_if.sv
// Carries synchronised host strobes from the synchroniser to the sequencer.
// Assumes both ends share the system clock.
`timescale 1ns/100ps
interface host_sync_if;
   logic select_n;
   logic write_n;
   modport src (output select_n, output write_n);
   modport dst (input select_n, input write_n);
endinterface : host_sync_if

// File: core/host_strobe_sync.sv
// Two-stage synchroniser for the host select and write strobes.
// Assumes the strobes are asynchronous to clk_i.
`timescale 1ns/100ps
module host_strobe_sync
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Raw strobes
   input wire logic host_select_n_i,
   input wire logic host_write_strobe_n_i,
   // Synchronised strobes
   host_sync_if.src sync
);
   logic [1:0] meta_reg;
   logic [1:0] stable_reg;
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta_reg <= host_sram_write_pkg::SYNC_RESET;
         stable_reg <= host_sram_write_pkg::SYNC_RESET;
      end
      else
      begin
         meta_reg <= {host_select_n_i, host_write_strobe_n_i}; // see RL2
         stable_reg <= meta_reg; // see RL2
      end
   end
   assign sync.select_n = stable_reg[1];
   assign sync.write_n = stable_reg[0];
endmodule : host_strobe_sync

// File: verif/host_seq_props.sv
// Port assertions for the host write sequencer.
// Bound from the bench; one clock domain.
`timescale 1ns/100ps
module host_seq_props
(
   // Watched ports
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic host_select_n_i,
   input wire logic host_write_strobe_n_i,
   input wire logic internal_request_i,
   input wire logic backoff_i,
   input wire logic host_acknowledge_n_o,
   input wire logic host_busy_o,
   input wire logic command_write_o,
   input wire logic addr_buffer_enable_n_o,
   input wire logic data_buffer_enable_n_o,
   input wire logic data_buffer_direction_o,
   input wire logic mem_chip_select_n_o,
   input wire logic mem_write_enable_n_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   sequence req_start;
      !host_busy_o && $rose(!host_select_n_i && !host_write_strobe_n_i);
   endsequence
   sequence no_stall;
      (!internal_request_i && !backoff_i && !host_select_n_i
       && !host_write_strobe_n_i) [*4];
   endsequence
   a_ack_latency: assert property (req_start ##1 no_stall
      |=> !host_acknowledge_n_o) else $error("ack late");
   a_sync_two: assert property ($rose(host_busy_o) |->
      $past(!host_select_n_i, 3) && $past(!host_write_strobe_n_i, 3))
      else $error("request taken unsynchronised");
   a_stall_holds: assert property ($fell(addr_buffer_enable_n_o) |->
      !$past(internal_request_i) && !$past(backoff_i)) else $error("stall");
   a_space_pick: assert property ($fell(addr_buffer_enable_n_o)
      && !backoff_i && !internal_request_i && !host_select_n_i
      |=> mem_chip_select_n_o == command_write_o) else $error("space");
   a_ack_drops: assert property ($fell(mem_chip_select_n_o) |=>
      !host_acknowledge_n_o && mem_chip_select_n_o
      && addr_buffer_enable_n_o && data_buffer_enable_n_o) else $error("c5");
   a_enable_dir: assert property (!data_buffer_enable_n_o |->
      !addr_buffer_enable_n_o
      && data_buffer_direction_o == host_sram_write_pkg::DIR_TO_RAM)
      else $error("buffers");
   a_ack_holds: assert property (!host_acknowledge_n_o
      && !host_select_n_i |=> !host_acknowledge_n_o) else $error("ack hold");
   a_recovery_gap: assert property ($rose(host_acknowledge_n_o) |->
      addr_buffer_enable_n_o [*3]) else $error("no recovery");
   a_we_phase: assert property (mem_write_enable_n_o)
      else $error("strobe low at rising edge");
endmodule : host_seq_props

// File: verif/host_bus_model.sv
// Host master model that also counts SRAM strobes.
// Drives its outputs just after rising edges of clk_i.
`timescale 1ns/100ps
module host_bus_model
(
   // From the sequencer
   input wire logic clk_i,
   input wire logic ack_n_i,
   input wire logic cs_n_i,
   input wire logic we_n_i,
   input wire logic cmd_i,
   // Host strobes
   output logic sel_n_o,
   output logic wr_n_o,
   output logic space_o
);
   int we_cnt = 0;
   int cs_cnt = 0;
   int cmd_cnt = 0;
   initial
   begin
      sel_n_o = 1'b1;
      wr_n_o = 1'b1;
      space_o = 1'b0;
   end
   // Strobe is only meaningful in the clock high phase
   // Looked at 1 ns into the high phase; the strobe is gone by the fall
   always @(posedge clk_i)
   begin
      #1;
      we_cnt += (we_n_i === 1'b0);
   end
   always @(posedge clk_i)
   begin
      cs_cnt += (cs_n_i === 1'b0);
      cmd_cnt += (cmd_i === 1'b1);
   end
   task automatic host_write(input logic sp, output int lat);
      int n;
      n = 0;
      lat = 0;
      sel_n_o <= 1'b0;
      wr_n_o <= 1'b0;
      space_o <= sp;
      do
      begin
         @(posedge clk_i);
         lat++;
      end
      while (ack_n_i !== 1'b0 && lat < 64);
      sel_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      space_o <= ~sp;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_n_i !== 1'b1 && n < 16);
   endtask : host_write
   task automatic glitch();
      sel_n_o <= 1'b0;
      wr_n_o <= 1'b0;
      @(posedge clk_i);
      sel_n_o <= 1'b1;
      wr_n_o <= 1'b1;
   endtask : glitch
endmodule : host_bus_model

// File: verif/host_sram_write_sequencer_bench.sv
// Self-checking bench for the host SRAM write sequencer.
// Host and SRAM side come from host_bus_model.
`timescale 1ns/100ps
module host_sram_write_sequencer_bench;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic internal_request_i = 1'b0;
   logic backoff_i = 1'b0;
   logic sel_n, wr_n, space, ack_n, busy, cmd, aen_n, den_n, dir, cs_n, we_n;
   logic [31:0] lfsr = 32'h34d8_0b38;
   int num_errors = 0;
   int compares = 0;
   int lat;
   initial
   begin
      forever #2 clk_i = ~clk_i;
   end
   host_sram_write_sequencer u_host_sram_write_sequencer (.clk_i, .resetn_i,
      .host_select_n_i(sel_n), .host_write_strobe_n_i(wr_n),
      .space_select_bit_i(space), .host_acknowledge_n_o(ack_n),
      .internal_request_i, .backoff_i, .host_busy_o(busy),
      .command_write_o(cmd), .addr_buffer_enable_n_o(aen_n),
      .data_buffer_enable_n_o(den_n), .data_buffer_direction_o(dir),
      .mem_chip_select_n_o(cs_n), .mem_write_enable_n_o(we_n));
   host_bus_model u_host_bus_model (.clk_i, .ack_n_i(ack_n), .cs_n_i(cs_n),
      .we_n_i(we_n), .cmd_i(cmd), .sel_n_o(sel_n), .wr_n_o(wr_n),
      .space_o(space));
   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : next_rand
   // A stall seen at the arbitration edge pushes the whole walk back
   function automatic int exp_lat(input int k);
      return (k > 2) ? k + host_sram_write_pkg::MAX_ACK_PERIODS - 1
         : host_sram_write_pkg::MAX_ACK_PERIODS + 1;
   endfunction : exp_lat
   task automatic check(input string what, input logic [31:0] e,
      input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", what, e, g);
      end
   endtask : check
   task automatic run(input logic sp, input int k, input logic bo);
      int we0, cs0, cm0;
      we0 = u_host_bus_model.we_cnt;
      cs0 = u_host_bus_model.cs_cnt;
      cm0 = u_host_bus_model.cmd_cnt;
      fork
         u_host_bus_model.host_write(sp, lat);
         if (k > 0)
         begin
            {backoff_i, internal_request_i} <= bo ? 2'b10 : 2'b01;
            repeat (k) @(posedge clk_i);
            {backoff_i, internal_request_i} <= 2'b00;
         end
      join
      check("latency", exp_lat(k), lat);
      check("cs cycles", !sp, u_host_bus_model.cs_cnt - cs0);
      check("cmd pulses", sp, u_host_bus_model.cmd_cnt - cm0);
      if (!sp) check("we pulses", 1, u_host_bus_model.we_cnt - we0);
      $display("write space %0b stall %0d done", sp, k);
   endtask : run
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test
   initial
   begin
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      check("idle outputs", 8'h9f, {ack_n, busy, cmd, aen_n, den_n, dir,
         cs_n, we_n});
      u_host_bus_model.glitch();
      repeat (4) @(posedge clk_i);
      check("busy after glitch", 0, busy);
      run(1'b0, 0, 1'b0);
      run(1'b1, 0, 1'b0);
      run(1'b0, 3, 1'b1);
      repeat (24)
      begin
         lfsr = next_rand(lfsr);
         run(lfsr[0], lfsr[4:1] % 11, lfsr[5]);
      end
      stop_test();
   end
   initial
   begin
      #20000;
      num_errors++;
      stop_test();
   end
endmodule : host_sram_write_sequencer_bench
bind host_sram_write_sequencer host_seq_props u_host_seq_props (.*);
